// [chip_reset_sequencer_test.sv]
// Self-checking bench for the chip reset sequencer.
`timescale 1ns/100ps
module chip_reset_sequencer_test;
  import crs_pkg::*;
  localparam int PH = 20;
  logic clk_in;
  logic rst_n_in = 1'b0;
  logic pin_n;
  logic wd = 1'b0;
  logic sw = 1'b0;
  logic slow = 1'b0;
  logic sys_n;
  logic [2:0] flags;
  logic csel;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  crs_pin_model P (.clk_in(clk_in), .pin_n_out(pin_n));
  crs_chip_reset_sequencer #(.PIN_HOLD_CYC(PH)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reset_pin_n_in(pin_n), .watchdog_timer_in(wd), .core_sw_reset_request_in(sw),
    .slow_mode_in(slow), .sys_reset_n_out(sys_n), .reset_source_flags_out(flags),
    .clk_sel_internal_out(csel));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc > 70000)
    begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input string s, input logic [2:0] e, input logic [2:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      bad_count++;
    end
  endtask
  task automatic wait_run();
    for (int i = 0; i < PH + 10 && sys_n !== 1'b1; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    chk("release", 3'h1, {2'h0, sys_n});
  endtask
  // Soft source expected in the flags; a refused request leaves the last software flag.
  function automatic logic [2:0] exp_flags(input int k);
    return (k == 0) ? 3'h1 << CRS_FLAG_WDT : 3'h1 << CRS_FLAG_SW;
  endfunction
  initial
  begin
    void'($urandom(8473));
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    while (pin_n !== 1'b1) @(posedge clk_in);
    repeat (PH - 5) @(posedge clk_in);
    #1 chk("pin hold", 3'h0, {2'h0, sys_n});
    wait_run();
    chk("flags", 3'h1 << CRS_FLAG_PIN, flags);
    chk("clk sel", 3'h1, {2'h0, csel});
    $display("cold reset test done");
    for (int i = 0; i < 6; i++)
    begin
      repeat ($urandom_range(1, 8)) @(posedge clk_in);
      #1 wd = (i % 3 == 0);
      sw = (i % 3 != 0);
      slow = (i % 3 == 2);
      @(posedge clk_in);
      #1 {wd, sw, slow} = 3'h0;
      chk("soft start", (i % 3 == 2), {2'h0, sys_n});
      chk("soft flags", exp_flags(i % 3), flags);
      repeat (28) @(posedge clk_in);
      #1 chk("soft hold", (i % 3 == 2), {2'h0, sys_n});
      repeat (2) @(posedge clk_in);
      #1 chk("soft end", 3'h1, {2'h0, sys_n});
    end
    $display("soft reset test done");
    P.warm(12 + $urandom_range(0, 4));
    #1 chk("warm low", 3'h0, {2'h0, sys_n});
    wait_run();
    chk("warm flags", 3'h1 << CRS_FLAG_PIN, flags);
    $display("warm reset test done");
    close_out();
  end
endmodule

// [crs_chip_reset_sequencer.sv]
// Reset sequencer: gathers reset sources and times the internal reset release.
`timescale 1ns/100ps
module crs_chip_reset_sequencer
  import crs_pkg::*;
#(
  parameter int PIN_HOLD_CYC = CRS_PIN_HOLD_CYC
)
(
  // Internal high-speed oscillator clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Reset sources
  input wire logic reset_pin_n_in,
  input wire logic watchdog_timer_in,
  input wire logic core_sw_reset_request_in,
  // Low-speed clock mode indication
  input wire logic slow_mode_in,
  // Outputs
  output logic sys_reset_n_out,
  output logic [2:0] reset_source_flags_out,
  output logic clk_sel_internal_out
);
  logic pin_n_sync;
  crs_state_e state;
  crs_state_e next_state;
  logic [CRS_CNT_W-1:0] cnt;
  logic [CRS_CNT_W-1:0] next_cnt;
  logic [CRS_CNT_W-1:0] load;
  logic from_pin;

  crs_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(reset_pin_n_in),
    .sync_out(pin_n_sync)
  );

  // A software request in low-speed mode is ignored because the core cannot be trusted to issue it there.
  wire sw_req = core_sw_reset_request_in && !slow_mode_in;
  wire pin_low = !pin_n_sync;
  wire soft_evt = (watchdog_timer_in || sw_req) && (state == CRS_RUN);
  wire done = (cnt == '0);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    load = from_pin ? CRS_CNT_W'(PIN_HOLD_CYC - 1) : CRS_CNT_W'(CRS_SOFT_HOLD_CYC - 1);
    if (pin_low)
    begin
      next_state = CRS_HOLD;
    end
    else
    begin
      case (state)
        CRS_HOLD:
        begin
          next_state = CRS_COUNT;
          next_cnt = load;
        end
        CRS_COUNT:
        begin
          if (done)
            next_state = CRS_RUN;
          else
            next_cnt = cnt - 1'b1;
        end
        default:
        begin
          if (soft_evt)
          begin
            next_state = CRS_COUNT;
            next_cnt = CRS_CNT_W'(CRS_SOFT_HOLD_CYC - 1);
          end
        end
      endcase
    end
  end

  // Release is a registered edge on the oscillator clock, so it never glitches.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= CRS_HOLD;
      cnt <= '0;
      from_pin <= 1'b1;
      sys_reset_n_out <= 1'b0;
      reset_source_flags_out <= CRS_FLAGS_RESET;
      clk_sel_internal_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sys_reset_n_out <= (next_state == CRS_RUN);
      clk_sel_internal_out <= 1'b1;
      if (pin_low)
      begin
        from_pin <= 1'b1;
        reset_source_flags_out <= 3'h1 << CRS_FLAG_PIN;
      end
      else if (soft_evt)
      begin
        from_pin <= 1'b0;
        reset_source_flags_out <= watchdog_timer_in ? (3'h1 << CRS_FLAG_WDT) : (3'h1 << CRS_FLAG_SW);
      end
    end
  end

  // Assertion helper: consecutive cycles with internal reset held low.
  // It saturates so that a long power-on hold can never wrap into a short count.
  logic [CRS_CNT_W-1:0] low_run_cnt;
  wire low_run_full = (low_run_cnt == '1);
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      low_run_cnt <= '0;
    end
    else if (sys_reset_n_out)
    begin
      low_run_cnt <= '0;
    end
    else if (!low_run_full)
    begin
      low_run_cnt <= low_run_cnt + 1'b1;
    end
  end

  // Assertions.
  property p_pin_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      $fell(pin_low) |-> !sys_reset_n_out [*8];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("reset released too soon after pin");

  property p_soft_release;
    @(posedge clk_in) disable iff (!rst_n_in)
      // Thirty low cycles and release on the next edge, unless the pin took over in between.
      (soft_evt && !pin_low) |-> ##31
        ((sys_reset_n_out && low_run_cnt == CRS_CNT_W'(CRS_SOFT_HOLD_CYC)) || pin_low || from_pin);
  endproperty
  a_soft_release: assert property (p_soft_release) else $error("soft reset timing wrong");

  property p_pin_asserts;
    @(posedge clk_in) disable iff (!rst_n_in)
      pin_low |=> !sys_reset_n_out;
  endproperty
  a_pin_asserts: assert property (p_pin_asserts) else $error("pin low did not reset");

  property p_wdt_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
      (soft_evt && watchdog_timer_in && !pin_low) |=> reset_source_flags_out == 3'h2;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag wrong");

  property p_pin_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
      pin_low |=> reset_source_flags_out == 3'h1;
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag wrong");

  property p_slow_ignored;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sys_reset_n_out && slow_mode_in && !watchdog_timer_in && !pin_low) |=> sys_reset_n_out;
  endproperty
  a_slow_ignored: assert property (p_slow_ignored) else $error("software reset taken in slow mode");

  property p_sw_request;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sys_reset_n_out && core_sw_reset_request_in && !slow_mode_in) |=> !sys_reset_n_out;
  endproperty
  a_sw_request: assert property (p_sw_request) else $error("software request ignored");

  property p_internal_clk;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(sys_reset_n_out) |-> clk_sel_internal_out;
  endproperty
  a_internal_clk: assert property (p_internal_clk) else $error("not on internal oscillator");

  property p_pin_release_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      ($rose(sys_reset_n_out) && from_pin) |-> (low_run_full || low_run_cnt > CRS_CNT_W'(PIN_HOLD_CYC));
  endproperty
  a_pin_release_len: assert property (p_pin_release_len) else $error("pin reset held too briefly");

  property p_soft_count_bound;
    @(posedge clk_in) disable iff (!rst_n_in)
      (state == CRS_COUNT && !from_pin) |-> cnt < CRS_CNT_W'(CRS_SOFT_HOLD_CYC);
  endproperty
  a_soft_count_bound: assert property (p_soft_count_bound) else $error("soft count out of range");

  property p_release_after_count;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(sys_reset_n_out) |-> (state == CRS_RUN) && ($past(state) == CRS_COUNT);
  endproperty
  a_release_after_count: assert property (p_release_after_count) else $error("release without count");

  property p_run_matches_release;
    @(posedge clk_in) disable iff (!rst_n_in)
      sys_reset_n_out == (state == CRS_RUN);
  endproperty
  a_run_matches_release: assert property (p_run_matches_release) else $error("release and state disagree");

  property p_pin_keeps_reset;
    @(posedge clk_in) disable iff (!rst_n_in)
      (pin_low && $past(pin_low)) |-> !sys_reset_n_out;
  endproperty
  a_pin_keeps_reset: assert property (p_pin_keeps_reset) else $error("reset released while pin low");

  property p_flags_onehot;
    @(posedge clk_in) disable iff (!rst_n_in)
      $onehot(reset_source_flags_out);
  endproperty
  a_flags_onehot: assert property (p_flags_onehot) else $error("reset source flags not one-hot");

  property p_flags_stable_in_reset;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!sys_reset_n_out && !pin_low) |=> $stable(reset_source_flags_out);
  endproperty
  a_flags_stable_in_reset: assert property (p_flags_stable_in_reset) else $error("flags changed during reset");

  property p_sw_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
      (soft_evt && !watchdog_timer_in && !pin_low) |=> reset_source_flags_out == (3'h1 << CRS_FLAG_SW);
  endproperty
  a_sw_flag: assert property (p_sw_flag) else $error("software flag wrong");
endmodule

// [crs_pin_model.sv]
// Behavioural reset pin driver with power-on supervision.
`timescale 1ns/100ps
module crs_pin_model #(
  parameter int POR_CYC = 50000
)
(
  // Clock and pin
  input wire logic clk_in,
  output logic pin_n_out
);
  // The pin stays low from power-on until the regulator has settled.
  initial
  begin
    pin_n_out = 1'b0;
    repeat (POR_CYC) @(posedge clk_in);
    #1 pin_n_out = 1'b1;
  end
  // Shorter pulses could slip past the synchroniser, so the low time is never below twelve clocks.
  task automatic warm(input int n);
    @(posedge clk_in);
    #1 pin_n_out = 1'b0;
    repeat ((n < 12) ? 12 : n) @(posedge clk_in);
    #1 pin_n_out = 1'b1;
  endtask
endmodule

// [crs_pkg.sv]
// Constants and types shared by the chip reset sequencer.
package crs_pkg;
  localparam int CRS_CLK_HZ = 50000000;
  localparam int CRS_PIN_HOLD_NS = 1600000;
  localparam int CRS_PIN_HOLD_CYC = (CRS_PIN_HOLD_NS / 1000) * (CRS_CLK_HZ / 1000000);
  localparam int CRS_SOFT_HOLD_CYC = 30;
  localparam int CRS_PIN_MIN_LOW_CYC = 12;
  localparam int CRS_CNT_W = 17;
  localparam logic [2:0] CRS_FLAGS_RESET = 3'h1;
  localparam int CRS_FLAG_PIN = 0;
  localparam int CRS_FLAG_WDT = 1;
  localparam int CRS_FLAG_SW = 2;
  typedef enum logic [1:0] {CRS_HOLD, CRS_COUNT, CRS_RUN} crs_state_e;
endpackage

// [crs_sync.sv]
// Two-flop synchroniser for the external reset pin.
`timescale 1ns/100ps
module crs_sync
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Asynchronous level and its synchronised copy
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
